// >>> smc_pkg.sv
// Constants and types for the serial monitor command unit.
// Assumes nothing beyond a SystemVerilog compiler; shared by the unit and its bench.
package smc_pkg;

    // Instruction register layout, index 0 is the first bit shifted out
    localparam int IR_W        = 25;
    localparam int PAR_POS     = 24;
    localparam int OP_MSB      = 23;
    localparam int OP_LSB      = 21;
    localparam int ADDR_MSB    = 20;
    localparam int ADDR_LSB    = 16;
    localparam int DATA_W      = 16;
    localparam int RESP_W      = 17;
    localparam int RESP_PAR    = 16;
    localparam int INS_W       = 24;

    // Protected bit counts per opcode
    localparam int PROT_FULL   = 24;
    localparam int PROT_NOOP   = 16;
    localparam int PROT_SHORT  = 8;

    // Field bit k sits at index DATA_W-1-k; these are the indices
    localparam int D_BIST      = 12;
    localparam int D_SCAN      = 11;
    localparam int D_CLK_LOW   = 9;
    localparam int D_HALT      = 8;
    localparam int D_DRV_EN    = 0;
    localparam int S_PAR_ERR   = 15;

    // Reset values
    localparam logic [IR_W-1:0]   IR_RESET     = 25'h0000000;
    localparam logic [DATA_W-1:0] STATUS_RESET = 16'h0000;
    localparam logic              DRV_EN_RESET = 1'b0;
    localparam logic              HALT_RESET   = 1'b0;
    localparam logic              SCAN_RESET   = 1'b0;
    localparam logic              PLL_RST_RESET = 1'b1;

    // Functional output enables gated by the driver command
    localparam int FUNC_OE_W   = 8;

    // Core clock cycles between steps of the clock start sequence
    localparam logic [2:0] SEQ_GAP = 3'h4;

    typedef enum logic [2:0] {
        SMC_OP_NOOP   = 3'b000,
        SMC_OP_ECHO   = 3'b001,
        SMC_OP_WRREG  = 3'b010,
        SMC_OP_RDREG  = 3'b011,
        SMC_OP_EVENT  = 3'b100,
        SMC_OP_RESET  = 3'b101,
        SMC_OP_STATUS = 3'b110,
        SMC_OP_DRV    = 3'b111
    } smc_op_t;

    typedef enum logic [1:0] {
        SMC_SEQ_IDLE  = 2'b00,
        SMC_SEQ_FAST  = 2'b01,
        SMC_SEQ_FLUSH = 2'b10
    } smc_seq_t;

endpackage : smc_pkg

// >>> smc_unit.sv
// Serial monitor command unit: instruction shift, parity check, execution,
// response shift-out, scan bypass, and the core-side event sequencing.
// Assumes the controller clocks serial_clk_in while rst_in is held so the link
// side resets too; serial pins are driven on the opposite edge by the controller.
// Core-side outputs follow the executing link edge by two to three core cycles; the fast reset and flush of clock start come later.
//
// Behaviour
// RL1 - Event instruction returns its data field as the response.
// RL2 - Event bit 3 set starts self test and ignores the other bits except bit 4.
// RL3 - Event bit 4 with bit 3 clear selects scan string or bypass bit.
// RL4 - Event bits 3 and 4 both set start the internal clock logic.
// RL5 - Internal PLL: clock start releases PLL reset, then fast reset, then flush.
// RL6 - External PLL: clock start gives fast reset then flush; controller waits lock.
// RL7 - Controller always sends event bit 6 as zero.
// RL8 - Event bit 7 halts the slow core clock, zero lets it run.
// RL9 - Reset opcode pulses a core flush reset, fields ignored.
// RL10 - Controller follows a reset instruction with an echo.
// RL11 - Read status copies the status register into the response.
// RL12 - Read status clears the status register after copying it.
// RL13 - Driver command enable is ANDed into the functional output enables.
// RL14 - Driver command data bit 15 enables drivers; data field is returned.
// RL15 - Response is the 17 low bits of the instruction register.
// RL16 - Every executed instruction loads 16 data bits into response bits 1 to 16.
// RL17 - Response bit 0 holds odd parity over the 16 data bits.
// RL18 - Response shifts out during the next instruction, bit 16 first.
// RL19 - Instruction executes one serial clock after select goes inactive.
// RL20 - Parity error inhibits execution, sets status bit 0, keeps response.
// RL21 - Controller shifts instructions LSB first with mode and select low.
// RL22 - Parity covers the top 24, 16 or 8 bits depending on opcode.
`timescale 1ns/10ps

module smc_unit (
    // Core clock and reset
    input  wire logic                          clk_in,
    input  wire logic                          rst_in,
    // Serial link, own clock
    input  wire logic                          serial_clk_in,
    input  wire logic                          serial_in_in,
    input  wire logic                          serial_select_n_in,
    input  wire logic                          serial_mode_sel_in,
    output logic                               serial_out_out,
    // Internal scan string, link clock domain
    input  wire logic                          scan_return_in,
    output logic                               scan_data_out,
    output logic                               scan_shift_out,
    // Core side controls
    input  wire logic                          use_internal_pll_in,
    input  wire logic [smc_pkg::FUNC_OE_W-1:0] func_oe_in,
    output logic      [smc_pkg::FUNC_OE_W-1:0] func_oe_out,
    output logic                               scan_string_sel_out,
    output logic                               core_clk_halt_out,
    output logic                               bist_start_out,
    output logic                               pll_reset_out,
    output logic                               fast_reset_out,
    output logic                               core_flush_out
);
    import smc_pkg::*;

    function automatic logic [4:0] prot_bits(input smc_op_t op);
        case (op)
            SMC_OP_NOOP:                             prot_bits = 5'(PROT_NOOP);
            SMC_OP_RDREG, SMC_OP_RESET, SMC_OP_STATUS: prot_bits = 5'(PROT_SHORT);
            default:                                 prot_bits = 5'(PROT_FULL);
        endcase
    endfunction : prot_bits

    // Odd parity over parity bit plus the top n instruction bits
    function automatic logic par_ok(input logic [IR_W-1:0] ir, input logic [4:0] n);
        logic acc;
        acc = ir[PAR_POS];
        for (int i = 0; i < INS_W; i++) begin
            if (i >= INS_W - int'(n)) begin
                acc = acc ^ ir[i];
            end
        end
        par_ok = acc;
    endfunction : par_ok

    // ---------------- Link clock domain ----------------
    logic                 lrst1_q;
    logic                 lrst_q;
    logic [IR_W-1:0]      ir_q;
    logic [IR_W-1:0]      ir_d;
    logic                 sel_n_q;
    logic                 ins_frame_q;
    logic                 exec_pend_q;
    logic [DATA_W-1:0]    status_q;
    logic                 bist_tgl_q;
    logic                 clk_start_tgl_q;
    logic                 flush_tgl_q;
    logic                 scan_sel_q;
    logic                 halt_q;
    logic                 drv_en_q;
    logic                 serial_out_q;
    logic                 scan_data_q;
    logic                 scan_shift_q;
    smc_op_t              op;
    logic [DATA_W-1:0]    data;
    logic [DATA_W-1:0]    resp_data;
    logic                 shift_en;
    logic                 scan_en;
    logic                 do_exec;
    logic                 par_err;

    // Reset brought into the link domain; first stage feeds only the second
    always_ff @(posedge serial_clk_in) begin
        lrst1_q <= rst_in;
        lrst_q  <= lrst1_q;
    end

    assign shift_en = !serial_mode_sel_in && !serial_select_n_in;
    assign scan_en  = serial_mode_sel_in && !serial_select_n_in;

    // Scan frames never execute: ins_frame_q keeps the mode seen while selected
    // Execute on the edge after the first edge that sees select inactive
    always_ff @(posedge serial_clk_in) begin
        if (lrst_q) begin
            sel_n_q     <= 1'b1;
            ins_frame_q <= 1'b0;
            exec_pend_q <= 1'b0;
        end else begin
            sel_n_q     <= serial_select_n_in;
            if (!serial_select_n_in) begin
                ins_frame_q <= !serial_mode_sel_in;
            end
            exec_pend_q <= !sel_n_q && serial_select_n_in && ins_frame_q; // RL19
        end
    end

    always_comb begin
        op        = smc_op_t'(ir_q[OP_MSB:OP_LSB]);
        data      = ir_q[DATA_W-1:0];
        do_exec   = exec_pend_q && par_ok(ir_q, prot_bits(op)); // RL22
        par_err   = exec_pend_q && !par_ok(ir_q, prot_bits(op));
        case (op)
            SMC_OP_NOOP:   resp_data = status_q;
            SMC_OP_STATUS: resp_data = status_q; // RL11
            SMC_OP_RESET:  resp_data = 16'h0000;
            SMC_OP_WRREG:  resp_data = data;
            SMC_OP_RDREG:  resp_data = 16'h0000;
            default:       resp_data = data; // RL1 RL14
        endcase
    end

    // Instruction and response share one register
    always_comb begin
        ir_d = ir_q;
        if (shift_en) begin
            ir_d = {serial_in_in, ir_q[IR_W-1:1]}; // RL18
        end else if (do_exec) begin
            // Odd parity in response bit 0, data in bits 1 to 16
            ir_d = {8'h00, !(^resp_data), resp_data}; // RL15 RL16 RL17
        end
    end

    always_ff @(posedge serial_clk_in) begin
        if (lrst_q) begin
            ir_q <= IR_RESET;
        end else begin
            ir_q <= ir_d; // RL20
        end
    end

    // A parity error outranks the clear; one frame cannot ask for both
    always_ff @(posedge serial_clk_in) begin
        if (lrst_q) begin
            status_q <= STATUS_RESET;
        end else if (par_err) begin
            status_q[S_PAR_ERR] <= 1'b1; // RL20
        end else if (do_exec && op == SMC_OP_STATUS) begin
            status_q <= STATUS_RESET; // RL12
        end
    end

    // Event and reset effects; pulses sent to the core as toggles, scan select and halt as levels
    // A one-cycle link pulse could fall between two slower core edges
    always_ff @(posedge serial_clk_in) begin
        if (lrst_q) begin
            bist_tgl_q      <= 1'b0;
            clk_start_tgl_q <= 1'b0;
            flush_tgl_q     <= 1'b0;
            scan_sel_q      <= SCAN_RESET;
            halt_q          <= HALT_RESET;
        end else if (do_exec) begin
            case (op)
                SMC_OP_EVENT: begin
                    if (data[D_BIST]) begin
                        bist_tgl_q <= !bist_tgl_q; // RL2
                        if (data[D_SCAN]) begin
                            clk_start_tgl_q <= !clk_start_tgl_q; // RL4
                        end
                    end else begin
                        scan_sel_q <= data[D_SCAN]; // RL3
                        halt_q     <= data[D_HALT]; // RL8
                    end
                end
                SMC_OP_RESET: begin
                    flush_tgl_q <= !flush_tgl_q; // RL9
                end
                default: begin
                end
            endcase
        end
    end

    // Drivers stay off after reset until the controller enables them
    always_ff @(posedge serial_clk_in) begin
        if (lrst_q) begin
            drv_en_q <= DRV_EN_RESET;
        end else if (do_exec && op == SMC_OP_DRV) begin
            drv_en_q <= data[D_DRV_EN]; // RL14
        end
    end

    // Serial out: response bit, or in scan mode the bypass bit or the string
    always_ff @(posedge serial_clk_in) begin
        if (lrst_q) begin
            serial_out_q <= 1'b0;
            scan_data_q  <= 1'b0;
            scan_shift_q <= 1'b0;
        end else begin
            if (scan_en) begin
                serial_out_q <= scan_sel_q ? scan_return_in : serial_in_in; // RL3
            end else begin
                serial_out_q <= ir_d[0]; // RL18
            end
            scan_data_q  <= serial_in_in;
            scan_shift_q <= scan_en && scan_sel_q;
        end
    end

    assign serial_out_out = serial_out_q;
    assign scan_data_out  = scan_data_q;
    assign scan_shift_out = scan_shift_q;

    // ---------------- Core clock domain ----------------
    logic [3:0]           lvl1_q;
    logic [3:0]           lvl2_q;
    logic [2:0]           tg1_q;
    logic [2:0]           tg2_q;
    logic [2:0]           tg3_q;
    logic [2:0]           ev_pulse;
    smc_seq_t             seq_q;
    logic [2:0]           cnt_q;
    logic [FUNC_OE_W-1:0] func_oe_q;
    logic                 scan_out_q;
    logic                 halt_out_q;
    logic                 bist_q;
    logic                 pll_rst_q;
    logic                 fast_q;
    logic                 flush_q;
    logic                 flush_pend_q;
    logic                 flush_req;

    // Levels through two flops; events as toggles, edge found after the second flop
    always_ff @(posedge clk_in) begin
        lvl1_q <= {use_internal_pll_in, drv_en_q, halt_q, scan_sel_q};
        lvl2_q <= lvl1_q;
        tg1_q  <= {flush_tgl_q, clk_start_tgl_q, bist_tgl_q};
        tg2_q  <= tg1_q;
        if (rst_in) begin
            tg3_q <= 3'h0;
        end else begin
            tg3_q <= tg2_q;
        end
    end

    assign ev_pulse = tg2_q ^ tg3_q;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            func_oe_q  <= '0;
            scan_out_q <= SCAN_RESET;
            halt_out_q <= HALT_RESET;
            bist_q     <= 1'b0;
        end else begin
            func_oe_q  <= func_oe_in & {FUNC_OE_W{lvl2_q[2]}}; // RL13
            scan_out_q <= lvl2_q[0];
            halt_out_q <= lvl2_q[1]; // RL8
            bist_q     <= ev_pulse[0]; // RL2
        end
    end

    // Reset-opcode flush is held back a cycle behind a flush on the pin; one in the same cycle as a sequence flush merges with it
    assign flush_req = ev_pulse[2] || flush_pend_q;

    // Clock start sequence; spacing keeps each reset clear of the previous step
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            seq_q     <= SMC_SEQ_IDLE;
            cnt_q     <= 3'h0;
            pll_rst_q <= PLL_RST_RESET;
            fast_q    <= 1'b0;
            flush_q   <= 1'b0;
            flush_pend_q <= 1'b0;
        end else begin
            fast_q  <= 1'b0;
            flush_q      <= flush_req && !flush_q; // RL9
            flush_pend_q <= flush_req && flush_q;
            case (seq_q)
                SMC_SEQ_IDLE: begin
                    if (ev_pulse[1]) begin
                        if (lvl2_q[3]) begin
                            pll_rst_q <= 1'b0; // RL5
                        end
                        cnt_q <= SEQ_GAP;
                        seq_q <= SMC_SEQ_FAST;
                    end
                end
                SMC_SEQ_FAST: begin
                    if (cnt_q == 3'h0) begin
                        fast_q <= 1'b1; // RL5 RL6
                        cnt_q  <= SEQ_GAP;
                        seq_q  <= SMC_SEQ_FLUSH;
                    end else begin
                        cnt_q <= cnt_q - 3'h1;
                    end
                end
                SMC_SEQ_FLUSH: begin
                    // Wait out a reset-opcode flush still on the pin
                    if (cnt_q != 3'h0) begin
                        cnt_q <= cnt_q - 3'h1;
                    end else if (!flush_q) begin
                        flush_q <= 1'b1; // RL5 RL6
                        seq_q   <= SMC_SEQ_IDLE;
                    end
                end
                default: begin
                    seq_q <= SMC_SEQ_IDLE;
                end
            endcase
        end
    end

    assign func_oe_out         = func_oe_q;
    assign scan_string_sel_out = scan_out_q;
    assign core_clk_halt_out   = halt_out_q;
    assign bist_start_out      = bist_q;
    assign pll_reset_out       = pll_rst_q;
    assign fast_reset_out      = fast_q;
    assign core_flush_out      = flush_q;

endmodule : smc_unit

// >>> smc_ctrl_model.sv
// Behavioural serial controller: shifts instructions, collects responses.
// Assumes it alone drives the link pins; the link clock runs only in frames and in pulse calls.
`timescale 1ns/10ps
module smc_ctrl_model (
    // Link pins
    output logic      sclk_out,
    output logic      sdata_out,
    output logic      select_n_out,
    output logic      mode_out,
    input  wire logic resp_in
);
    import smc_pkg::*;
    initial begin
        sclk_out = 1'b0;
        sdata_out = 1'b0;
        select_n_out = 1'b1;
        mode_out = 1'b0;
    end
    // Pins only move in the low half, away from the sampling edge
    task automatic pulse(input int n);
        repeat (n) begin
            #15 sclk_out = 1'b1;
            #15 sclk_out = 1'b0;
        end
    endtask : pulse
    task automatic xfer(input logic [2:0] op, input logic [15:0] d, input int n, input bit bad,
                        output logic [16:0] rsp);
        logic [24:0] w;
        logic        p;
        w = {1'b0, op, 5'h00, d};
        if (op == SMC_OP_EVENT) w[D_CLK_LOW] = 1'b0;
        p = 1'b1;
        for (int i = 24 - n; i < 24; i++) p = p ^ w[i];
        w[24] = p ^ bad;
        rsp = '0;
        mode_out = 1'b0;
        for (int i = 0; i <= n; i++) begin
            sdata_out = w[24 - n + i];
            select_n_out = 1'b0;
            #15;
            if (i < 17) rsp[i] = resp_in;
            sclk_out = 1'b1;
            #15 sclk_out = 1'b0;
        end
        select_n_out = 1'b1;
        // Released data line must not keep showing the last bit
        sdata_out = ~sdata_out;
        pulse(2);
    endtask : xfer
    // Scan frame of eight bits; q[i] is the link output seen before edge i
    task automatic scan(input logic [7:0] d, output logic [7:0] q);
        mode_out = 1'b1;
        for (int i = 0; i < 8; i++) begin
            sdata_out = d[i];
            select_n_out = 1'b0;
            #15;
            q[i] = resp_in;
            sclk_out = 1'b1;
            #15 sclk_out = 1'b0;
        end
        select_n_out = 1'b1;
        sdata_out = ~sdata_out;
        pulse(2);
    endtask : scan
endmodule : smc_ctrl_model

// >>> smc_unit_asserts.sv
// Checker for the serial monitor command unit, bound to its top ports.
// Assumes a steady PLL strap while clock start runs.
`timescale 1ns/10ps
module smc_unit_chk (
    // Clocks and reset
    input wire logic                          clk_in,
    input wire logic                          rst_in,
    input wire logic                          serial_clk_in,
    // Observed pins
    input wire logic                          serial_mode_sel_in,
    input wire logic [smc_pkg::FUNC_OE_W-1:0] func_oe_in,
    input wire logic [smc_pkg::FUNC_OE_W-1:0] func_oe_out,
    input wire logic                          core_clk_halt_out,
    input wire logic                          bist_start_out,
    input wire logic                          pll_reset_out,
    input wire logic                          fast_reset_out,
    input wire logic                          core_flush_out,
    input wire logic                          scan_shift_out
);
    import smc_pkg::*;
    chk_bist_one_cycle: assert property (@(posedge clk_in) disable iff (rst_in)
        bist_start_out |=> !bist_start_out) else $error("bist start wider than one cycle");
    chk_bist_keeps_halt: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(bist_start_out) |-> $stable(core_clk_halt_out)) else $error("halt moved with bist");
    chk_fast_one_cycle: assert property (@(posedge clk_in) disable iff (rst_in)
        fast_reset_out |=> !fast_reset_out) else $error("fast reset wider than one cycle");
    chk_flush_one_cycle: assert property (@(posedge clk_in) disable iff (rst_in)
        core_flush_out |=> !core_flush_out) else $error("flush wider than one cycle");
    chk_pll_stays_released: assert property (@(posedge clk_in) disable iff (rst_in)
        !pll_reset_out |=> !pll_reset_out) else $error("pll reset came back");
    chk_pll_then_fast: assert property (@(posedge clk_in) disable iff (rst_in)
        $fell(pll_reset_out) |-> ##[1:12] fast_reset_out) else $error("no fast reset after pll release");
    chk_fast_then_flush: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(fast_reset_out) |-> ##[1:12] core_flush_out) else $error("no flush after fast reset");
    chk_oe_gated_and: assert property (@(posedge clk_in) disable iff (rst_in)
        (func_oe_out & ~$past(func_oe_in)) == '0) else $error("enable out without enable in");
    chk_scan_shift_mode: assert property (@(posedge serial_clk_in) disable iff (rst_in)
        !serial_mode_sel_in |=> !scan_shift_out) else $error("scan shift outside scan mode");
    cov_bist: cover property (@(posedge clk_in) $rose(bist_start_out));
    cov_fast: cover property (@(posedge clk_in) $rose(fast_reset_out));
    cov_flush: cover property (@(posedge clk_in) $rose(core_flush_out));
    cov_scan: cover property (@(posedge serial_clk_in) $rose(scan_shift_out));
endmodule : smc_unit_chk

bind smc_unit smc_unit_chk i_chk (
    .clk_in(clk_in), .rst_in(rst_in), .serial_clk_in(serial_clk_in),
    .serial_mode_sel_in(serial_mode_sel_in), .func_oe_in(func_oe_in), .func_oe_out(func_oe_out),
    .core_clk_halt_out(core_clk_halt_out), .bist_start_out(bist_start_out),
    .pll_reset_out(pll_reset_out), .fast_reset_out(fast_reset_out),
    .core_flush_out(core_flush_out), .scan_shift_out(scan_shift_out)
);

// >>> serial_monitor_command_unit_test.sv
// Self-checking bench for the serial monitor command unit.
// Assumes smc_ctrl_model drives the link and the checker is bound in.
`timescale 1ns/10ps
module serial_monitor_command_unit_test;
    import smc_pkg::*;
    logic                 clk_in, rst_in, sclk, sdata, sel_n, mode, sout, use_pll;
    logic                 halt, scan_sel, bist, pll_rst, fast, flush, sdo, sshift;
    logic [FUNC_OE_W-1:0] oe_in, oe_out;
    logic [16:0]          rsp;
    int                   n_errors = 0;
    int                   n_compared = 0;
    int                   n_shift = 0;

    // One-bit scan string: scan data out loops back to the return
    smc_unit i_dut (
        .clk_in(clk_in), .rst_in(rst_in), .serial_clk_in(sclk), .serial_in_in(sdata),
        .serial_select_n_in(sel_n), .serial_mode_sel_in(mode), .serial_out_out(sout),
        .scan_return_in(sdo), .scan_data_out(sdo), .scan_shift_out(sshift),
        .use_internal_pll_in(use_pll), .func_oe_in(oe_in), .func_oe_out(oe_out),
        .scan_string_sel_out(scan_sel), .core_clk_halt_out(halt), .bist_start_out(bist),
        .pll_reset_out(pll_rst), .fast_reset_out(fast), .core_flush_out(flush)
    );
    smc_ctrl_model i_ctrl (
        .sclk_out(sclk), .sdata_out(sdata), .select_n_out(sel_n), .mode_out(mode), .resp_in(sout)
    );

    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    // Link edges after which the scan string is shifting
    always @(negedge sclk) begin
        if (sshift === 1'b1) n_shift++;
    end

    task automatic tick();
        @(posedge clk_in);
        #2;
    endtask : tick
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [16:0] resp_of(input logic [15:0] d);
        return {~^d, d};
    endfunction : resp_of
    function automatic logic pick(input int s);
        case (s)
            0: return bist;
            1: return fast;
            default: return flush;
        endcase
    endfunction : pick
    // Bounded wait for a core pulse
    task automatic wait_hi(input int s);
        for (int k = 0; k < 40 && pick(s) !== 1'b1; k++) tick();
    endtask : wait_hi

    task automatic t_echo();
        chk({pll_rst, bist, fast, flush, halt, scan_sel, oe_out}, {6'b100000, 8'h00});
        i_ctrl.xfer(SMC_OP_ECHO, 16'ha5c3, 24, 0, rsp);
        i_ctrl.xfer(SMC_OP_ECHO, 16'h0001, 24, 0, rsp);
        chk(rsp, resp_of(16'ha5c3));
        i_ctrl.xfer(SMC_OP_NOOP, 16'h0000, 16, 0, rsp);
        chk(rsp, resp_of(16'h0001));
        $display("echo test done");
    endtask : t_echo
    task automatic t_event();
        i_ctrl.xfer(SMC_OP_EVENT, 16'h0900, 24, 0, rsp);
        repeat (8) tick();
        chk({halt, scan_sel}, 2'b11);
        i_ctrl.xfer(SMC_OP_EVENT, 16'h0000, 24, 0, rsp);
        chk(rsp, resp_of(16'h0900));
        repeat (8) tick();
        chk({halt, scan_sel}, 2'b00);
        // Halt bit set but must be ignored beside bist
        i_ctrl.xfer(SMC_OP_EVENT, 16'h1100, 24, 0, rsp);
        wait_hi(0);
        chk(bist, 1'b1);
        tick();
        chk({bist, halt}, 2'b00);
        $display("event test done");
    endtask : t_event
    task automatic t_clock_start(input logic internal);
        use_pll = internal;
        repeat (4) tick();
        i_ctrl.xfer(SMC_OP_EVENT, 16'h1800, 24, 0, rsp);
        wait_hi(1);
        chk(fast, 1'b1);
        chk(pll_rst, !internal);
        wait_hi(2);
        chk(flush, 1'b1);
        $display("clock start test done");
    endtask : t_clock_start
    task automatic t_reset_cmd();
        i_ctrl.xfer(SMC_OP_RESET, 16'hffff, 8, 0, rsp);
        wait_hi(2);
        chk(flush, 1'b1);
        i_ctrl.xfer(SMC_OP_ECHO, 16'h3c3c, 24, 0, rsp);
        chk(rsp, resp_of(16'h0000));
        $display("reset command test done");
    endtask : t_reset_cmd
    task automatic t_parity();
        i_ctrl.xfer(SMC_OP_ECHO, 16'h1234, 24, 1, rsp);
        i_ctrl.xfer(SMC_OP_NOOP, 16'h0000, 16, 0, rsp);
        chk(rsp, {1'b0, 16'h1234});
        i_ctrl.xfer(SMC_OP_STATUS, 16'h0000, 8, 0, rsp);
        i_ctrl.xfer(SMC_OP_NOOP, 16'h0000, 16, 0, rsp);
        chk(rsp, resp_of(16'h8000));
        i_ctrl.xfer(SMC_OP_NOOP, 16'h0000, 16, 0, rsp);
        chk(rsp, resp_of(16'h0000));
        $display("parity test done");
    endtask : t_parity
    task automatic t_drv();
        tick();
        oe_in = 8'h5a;
        i_ctrl.xfer(SMC_OP_DRV, 16'h0001, 24, 0, rsp);
        repeat (8) tick();
        chk(oe_out, 8'h5a);
        oe_in = 8'ha5;
        repeat (2) tick();
        chk(oe_out, 8'ha5);
        i_ctrl.xfer(SMC_OP_DRV, 16'h8000, 24, 0, rsp);
        chk(rsp, resp_of(16'h0001));
        repeat (8) tick();
        chk(oe_out, 8'h00);
        i_ctrl.xfer(SMC_OP_NOOP, 16'h0000, 16, 0, rsp);
        chk(rsp, resp_of(16'h8000));
        $display("driver test done");
    endtask : t_drv
    task automatic t_scan();
        logic [7:0] q;
        int         s0;
        s0 = n_shift;
        i_ctrl.scan(8'hb4, q);
        chk(q[7:1], 7'h34);
        chk(n_shift - s0, 0);
        i_ctrl.xfer(SMC_OP_EVENT, 16'h0800, 24, 0, rsp);
        s0 = n_shift;
        i_ctrl.scan(8'h6d, q);
        chk(q[7:2], 6'h2d);
        chk(n_shift - s0, 8);
        $display("scan test done");
    endtask : t_scan

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    initial begin
        #300000;
        n_errors++;
        test_done();
    end
    initial begin
        rst_in = 1'b1;
        use_pll = 1'b0;
        oe_in = '0;
        // Link clock must run while reset is held
        fork
            repeat (5) @(posedge clk_in);
            i_ctrl.pulse(8);
        join
        tick();
        rst_in = 1'b0;
        i_ctrl.pulse(3);
        t_echo();
        t_event();
        t_clock_start(1'b0);
        t_clock_start(1'b1);
        t_reset_cmd();
        t_parity();
        t_drv();
        t_scan();
        test_done();
    end
endmodule : serial_monitor_command_unit_test
